//--- logic/usb_evt_pkg.sv
// Notes on behaviour
// - End of bus reset sets end-of-reset flag until firmware clears it.
// - Bus reset end restores USB registers; controller stays enabled.
// - Stall request answers next request on selected endpoint with STALL.
// - Sent STALL sets stall-sent flag and interrupt; firmware clears both.
// - Valid SETUP PID on control endpoint clears stall request.
// - Received SETUP packet clears the stall-sent flag.
// - Start-of-frame PID sets frame-start flag; firmware clears it.
// - Start-of-frame stores its frame number in low and high registers.
// - Last start-of-frame CRC sets either CRC-good or CRC-error flag.
// - Accepted DATA0 sets toggle bit, accepted DATA1 clears it.
// - Endpoint reset through endpoint-reset register clears toggle bit.
// - SETUP uses DATA0, data alternates, status stage uses DATA1.
// - NAK to IN sets NAK-on-IN, to OUT sets NAK-on-OUT; software clears.
// - Enabled and clocked, bus idle over 3 ms sets suspend flag.
// - Clearing suspend flag idles the pad; wake-up event leaves idle.
// - While suspended, non-idle bus sets CPU-wake flag, even unclocked.
// - Upstream resume sent only after 5 ms suspended; active bit shows it.
// - Finished upstream resume clears the active bit by hardware.
// - Detach bit floats pull-up reference output; clear drives it.
package usb_evt_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int IDLE_US = 3000;
    localparam int SUSP_MIN_US = 5000;
    localparam int RESUME_US = 10000;
    localparam int IDLE_CYC = (CLK_HZ / 1_000_000) * IDLE_US + 1;
    localparam int SUSP_CYC = (CLK_HZ / 1_000_000) * SUSP_MIN_US;
    localparam int RESUME_CYC = (CLK_HZ / 1_000_000) * RESUME_US;
    localparam int CW = 24;
    // Word offsets (byte addresses)
    localparam logic [7:0] A_EVENT = 8'h00;
    localparam logic [7:0] A_ENABLE = 8'h04;
    localparam logic [7:0] A_GCTRL = 8'h08;
    localparam logic [7:0] A_EPSEL = 8'h0c;
    localparam logic [7:0] A_EPSTAT = 8'h10;
    localparam logic [7:0] A_EPRST = 8'h14;
    localparam logic [7:0] A_FNUML = 8'h18;
    localparam logic [7:0] A_FNUMH = 8'h1c;
    localparam logic [7:0] A_PRIO = 8'h20;
    // Event register fields
    localparam int EV_EOR = 0;
    localparam int EV_SOF = 1;
    localparam int EV_SUSP = 2;
    localparam int EV_WAKE = 3;
    // Global control fields
    localparam int GC_EN = 7;
    localparam int GC_SUSPEND_CLOCK_GATE = 6;
    localparam int GC_SENDWU = 5;
    localparam int GC_DETACH = 4;
    localparam int GC_UPRES = 3;
    localparam int GC_RWUEN = 2;
    // Endpoint status fields
    localparam int ES_STALL_REQUEST = 0;
    localparam int ES_STALLSENT = 1;
    localparam int ES_NAK_ON_IN_FLAG = 2;
    localparam int ES_NAK_ON_OUT_FLAG = 3;
    localparam int ES_TOGGLE = 4;
    localparam int ES_FRAME_CRC_GOOD = 5;
    localparam int ES_FRAME_CRC_ERROR = 6;
    localparam logic [7:0] GC_RESET = 8'h00;
    localparam int NEP = 8;
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_WAIT = 2'b01,
        RS_SEND = 2'b11
    } res_state_t;
endpackage

//--- logic/usb_bus_events.sv
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module usb_bus_events #(
    parameter int IDLE_CYCLES = usb_evt_pkg::IDLE_CYC,
    parameter int SUSP_CYCLES = usb_evt_pkg::SUSP_CYC,
    parameter int RESUME_CYCLES = usb_evt_pkg::RESUME_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic bus_reset_end,
    input wire logic sof_pulse,
    input wire logic [10:0] sof_frame,
    input wire logic sof_crc_ok,
    input wire logic setup_pulse,
    input wire logic setup_is_control,
    input wire logic [2:0] tok_ep,
    input wire logic token_pulse,
    input wire logic data_accept,
    input wire logic data_pid1,
    input wire logic nak_in_sent,
    input wire logic nak_out_sent,
    input wire logic bus_idle,
    output logic send_stall,
    output logic expect_data1,
    output logic pad_idle,
    output logic resume_drive,
    output logic vref_out,
    output logic vref_oe_n,
    output logic usb_irq,
    output logic [1:0] usb_prio
);
    import usb_evt_pkg::*;

    logic [7:0] gctrl_q;
    logic [3:0] event_q;
    logic [7:0] enable_q;
    logic [2:0] epsel_q;
    logic [1:0] prio_q;
    logic [10:0] fnum_q;
    logic crc_ok_q;
    logic crc_err_q;
    logic [NEP-1:0] stall_request_q;
    logic [NEP-1:0] stallsent_q;
    logic [NEP-1:0] nak_on_in_flag_q;
    logic [NEP-1:0] nak_on_out_flag_q;
    logic [NEP-1:0] toggle_q;
    logic [NEP-1:0] ctl_phase_q;
    logic [CW-1:0] idle_cnt_q;
    logic [CW-1:0] susp_cnt_q;
    logic [CW-1:0] res_cnt_q;
    res_state_t rs_q;
    logic pad_idle_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic irq_q;

    logic wr;
    logic clocks_on;
    logic usb_rst;
    logic [3:0] ev_set;
    logic [7:0] flags;

    assign clocks_on = gctrl_q[GC_EN] && !gctrl_q[GC_SUSPEND_CLOCK_GATE];
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
    // Bus reset wipes USB registers but leaves enable set
    assign usb_rst = bus_reset_end && gctrl_q[GC_EN];

    always_comb begin
        ev_set = 4'h0;
        // Ignored while the controller is disabled
        ev_set[EV_EOR] = bus_reset_end && gctrl_q[GC_EN];
        ev_set[EV_SOF] = sof_pulse && clocks_on;
        ev_set[EV_SUSP] = clocks_on
            && idle_cnt_q == CW'(IDLE_CYCLES);
        // Wake detect runs without the USB clock gate
        ev_set[EV_WAKE] = gctrl_q[GC_EN] && pad_idle_q
            && !bus_idle;
    end

    // Bus slave: one wait state, ack for one cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else if (clk_en) begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end
    assign wb_ack_o = ack_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdat_q <= 32'h0;
        end else if (clk_en && wb_cyc_i && wb_stb_i && !ack_q) begin
            case (wb_adr_i)
                A_EVENT: rdat_q <= {28'h0, event_q};
                A_ENABLE: rdat_q <= {24'h0, enable_q};
                A_GCTRL: rdat_q <= {24'h0, gctrl_q};
                A_EPSEL: rdat_q <= {29'h0, epsel_q};
                A_EPSTAT: rdat_q <= {25'h0, crc_err_q, crc_ok_q,
                    toggle_q[epsel_q], nak_on_out_flag_q[epsel_q], nak_on_in_flag_q[epsel_q],
                    stallsent_q[epsel_q], stall_request_q[epsel_q]};
                A_FNUML: rdat_q <= {24'h0, fnum_q[7:0]};
                A_FNUMH: rdat_q <= {29'h0, fnum_q[10:8]};
                A_PRIO: rdat_q <= {30'h0, prio_q};
                default: rdat_q <= 32'h0;
            endcase
        end
    end
    assign wb_dat_o = rdat_q;

    // Global control; hardware owns the upstream-resume bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gctrl_q <= GC_RESET;
        end else if (clk_en) begin
            if (usb_rst) begin
                gctrl_q <= GC_RESET;
                gctrl_q[GC_EN] <= 1'b1;
            end else begin
                if (wr && wb_adr_i == A_GCTRL) begin
                    gctrl_q <= wb_dat_i[7:0];
                    gctrl_q[GC_UPRES] <= gctrl_q[GC_UPRES];
                end
                if (rs_q == RS_SEND) begin
                    gctrl_q[GC_UPRES] <= 1'b1;
                end else begin
                    gctrl_q[GC_UPRES] <= 1'b0;
                end
            end
        end
    end

    // Sticky events, write one to clear, set beats clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            event_q <= 4'h0;
        end else if (clk_en) begin
            if (usb_rst) begin
                event_q <= 4'h1;
            end else if (wr && wb_adr_i == A_EVENT) begin
                event_q <= (event_q & ~wb_dat_i[3:0]) | ev_set;
            end else begin
                event_q <= event_q | ev_set;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enable_q <= 8'h0;
            epsel_q <= 3'h0;
            prio_q <= 2'h0;
        end else if (clk_en) begin
            if (usb_rst) begin
                enable_q <= 8'h0;
                epsel_q <= 3'h0;
                prio_q <= 2'h0;
            end else if (wr) begin
                if (wb_adr_i == A_ENABLE) enable_q <= wb_dat_i[7:0];
                if (wb_adr_i == A_EPSEL) epsel_q <= wb_dat_i[2:0];
                if (wb_adr_i == A_PRIO) prio_q <= wb_dat_i[1:0];
            end
        end
    end

    // Frame number and CRC status of the latest frame start
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fnum_q <= 11'h0;
            crc_ok_q <= 1'b0;
            crc_err_q <= 1'b0;
        end else if (clk_en) begin
            if (usb_rst) begin
                fnum_q <= 11'h0;
                crc_ok_q <= 1'b0;
                crc_err_q <= 1'b0;
            end else if (sof_pulse && clocks_on) begin
                fnum_q <= sof_frame;
                crc_ok_q <= sof_crc_ok;
                crc_err_q <= !sof_crc_ok;
            end
        end
    end

    // Per-endpoint stall, NAK and toggle state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stall_request_q <= '0;
            stallsent_q <= '0;
            nak_on_in_flag_q <= '0;
            nak_on_out_flag_q <= '0;
            toggle_q <= '0;
            ctl_phase_q <= '0;
        end else if (clk_en) begin
            if (usb_rst) begin
                stall_request_q <= '0;
                stallsent_q <= '0;
                nak_on_in_flag_q <= '0;
                nak_on_out_flag_q <= '0;
                toggle_q <= '0;
                ctl_phase_q <= '0;
            end else begin
                if (wr && wb_adr_i == A_EPSTAT) begin
                    stall_request_q[epsel_q] <= wb_dat_i[ES_STALL_REQUEST];
                    if (wb_dat_i[ES_STALLSENT]) stallsent_q[epsel_q] <= 1'b0;
                    if (wb_dat_i[ES_NAK_ON_IN_FLAG]) nak_on_in_flag_q[epsel_q] <= 1'b0;
                    if (wb_dat_i[ES_NAK_ON_OUT_FLAG]) nak_on_out_flag_q[epsel_q] <= 1'b0;
                end
                if (wr && wb_adr_i == A_EPRST) begin
                    for (int i = 0; i < NEP; i++) begin
                        if (wb_dat_i[i]) toggle_q[i] <= 1'b0;
                    end
                end
                // Hardware events follow the writes so a same-cycle hardware update wins
                if (token_pulse && stall_request_q[tok_ep]) begin
                    stallsent_q[tok_ep] <= 1'b1;
                end
                if (nak_in_sent) nak_on_in_flag_q[tok_ep] <= 1'b1;
                if (nak_out_sent) nak_on_out_flag_q[tok_ep] <= 1'b1;
                if (data_accept) begin
                    toggle_q[tok_ep] <= !data_pid1;
                    ctl_phase_q[tok_ep] <= !ctl_phase_q[tok_ep];
                end
                if (setup_pulse) begin
                    stallsent_q[tok_ep] <= 1'b0;
                    ctl_phase_q[tok_ep] <= 1'b1;
                    if (setup_is_control) stall_request_q[tok_ep] <= 1'b0;
                end
            end
        end
    end

    // Stall only when the token hits a requesting endpoint
    assign send_stall = token_pulse && stall_request_q[tok_ep];
    assign expect_data1 = ctl_phase_q[tok_ep];

    // Idle length counter saturates one past the limit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idle_cnt_q <= '0;
        end else if (clk_en) begin
            if (!bus_idle || !clocks_on || usb_rst) begin
                idle_cnt_q <= '0;
            end else if (idle_cnt_q <= CW'(IDLE_CYCLES)) begin
                idle_cnt_q <= idle_cnt_q + 1'b1;
            end
        end
    end

    // Pad idles on flag clear; wake-up releases it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pad_idle_q <= 1'b0;
        end else if (clk_en) begin
            if (usb_rst || !bus_idle || rs_q == RS_SEND) begin
                pad_idle_q <= 1'b0;
            end else if (wr && wb_adr_i == A_EVENT && wb_dat_i[EV_SUSP]
                    && event_q[EV_SUSP]) begin
                pad_idle_q <= 1'b1;
            end
        end
    end
    assign pad_idle = pad_idle_q;

    // Suspended-time counter for upstream resume
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            susp_cnt_q <= '0;
        end else if (clk_en) begin
            if (!bus_idle || usb_rst) begin
                susp_cnt_q <= '0;
            end else if (susp_cnt_q < CW'(SUSP_CYCLES)) begin
                susp_cnt_q <= susp_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rs_q <= RS_IDLE;
            res_cnt_q <= '0;
        end else if (clk_en) begin
            case (rs_q)
                RS_IDLE: begin
                    if (gctrl_q[GC_SENDWU] && gctrl_q[GC_RWUEN] && clocks_on
                            && !event_q[EV_SUSP]) begin
                        rs_q <= RS_WAIT;
                    end
                end
                RS_WAIT: begin
                    if (!gctrl_q[GC_SENDWU] || usb_rst) begin
                        rs_q <= RS_IDLE;
                    end else if (susp_cnt_q == CW'(SUSP_CYCLES)) begin
                        rs_q <= RS_SEND;
                        res_cnt_q <= '0;
                    end
                end
                RS_SEND: begin
                    if (res_cnt_q == CW'(RESUME_CYCLES - 1) || usb_rst) begin
                        rs_q <= RS_IDLE;
                    end else begin
                        res_cnt_q <= res_cnt_q + 1'b1;
                    end
                end
                default: rs_q <= RS_IDLE;
            endcase
        end
    end
    assign resume_drive = rs_q == RS_SEND;

    // Reference drives high while attached
    assign vref_oe_n = gctrl_q[GC_DETACH];
    assign vref_out = 1'b1;

    always_comb begin
        flags = 8'h00;
        flags[3:0] = event_q;
        // Endpoint flags are summed over every endpoint
        flags[4] = |nak_on_in_flag_q;
        flags[5] = |nak_on_out_flag_q;
        flags[6] = |stallsent_q;
    end

    // Registered so enable writes cannot glitch the request line
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= |(flags & enable_q);
        end
    end
    assign usb_irq = irq_q;
    assign usb_prio = prio_q;
endmodule

//--- tb/usb_host_model.sv
`timescale 1ns/100ps
module usb_host_model (
    input wire logic sys_clk,
    output logic bus_reset_end,
    output logic sof_pulse,
    output logic [10:0] sof_frame,
    output logic sof_crc_ok,
    output logic setup_pulse,
    output logic setup_is_control,
    output logic [2:0] tok_ep,
    output logic token_pulse,
    output logic data_accept,
    output logic data_pid1,
    output logic nak_in_sent,
    output logic nak_out_sent,
    output logic bus_idle,
    input wire logic send_stall,
    input wire logic expect_data1
);
    logic stalled = 0;
    logic d1 = 0;
    logic [6:0] p_q = 7'h00;
    assign {bus_reset_end, sof_pulse, setup_pulse, token_pulse} = p_q[6:3];
    assign {data_accept, nak_in_sent, nak_out_sent} = p_q[2:0];
    initial begin
        {sof_frame, tok_ep, bus_idle} = 15'h0000;
        {sof_crc_ok, data_pid1, setup_is_control} = 3'h0;
    end
    // Stale qualifiers are inverted so a late read never looks valid
    task automatic ev(input int k, input logic [10:0] v, input logic b);
        @(posedge sys_clk);
        p_q <= 7'h40 >> k;
        sof_frame <= v;
        tok_ep <= v[2:0];
        {sof_crc_ok, data_pid1, setup_is_control} <= {3{b}};
        @(posedge sys_clk);
        stalled = send_stall;
        d1 = expect_data1;
        p_q <= 7'h00;
        sof_frame <= ~v;
        tok_ep <= ~v[2:0];
        {sof_crc_ok, data_pid1, setup_is_control} <= {3{~b}};
    endtask
    task automatic idle(input logic b);
        @(posedge sys_clk);
        bus_idle <= b;
    endtask
endmodule

//--- tb/usb_bus_events_chk.sv
`timescale 1ns/100ps
module usb_bus_events_chk import usb_evt_pkg::*; #(
    parameter int SUSP_CYCLES = 30,
    parameter int RESUME_CYCLES = 10
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input logic wb_ack_o,
    input wire logic bus_reset_end,
    input wire logic token_pulse,
    input wire logic bus_idle,
    input logic send_stall,
    input logic pad_idle,
    input logic resume_drive,
    input logic vref_out,
    input wire logic vref_oe_n,
    input logic [1:0] usb_prio
);
    int idle_q;
    int run_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) idle_q <= 0;
        else idle_q <= bus_idle ? idle_q + 1 : 0;
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) run_q <= 0;
        else run_q <= resume_drive ? run_q + 1 : 0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en
        |=> wb_ack_o) else $error("ack late");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack long");
    AST_STALL_TOKEN: assert property (send_stall |-> token_pulse)
        else $error("stall without token");
    AST_VREF_DRIVEN: assert property (vref_out)
        else $error("vref low");
    AST_DETACH_WRITE: assert property ($changed(vref_oe_n)
        |-> $past(wb_cyc_i && wb_we_i && wb_adr_i == A_GCTRL) ||
        $past(bus_reset_end)) else $error("detach changed");
    AST_PAD_WAKE: assert property (pad_idle && !bus_idle && clk_en
        |-> ##[1:2] !pad_idle) else $error("pad stays idle");
    AST_PAD_SET: assert property ($rose(pad_idle)
        |-> $past(wb_cyc_i && wb_we_i && wb_adr_i == A_EVENT))
        else $error("pad idle without clear");
    AST_RES_ARMED: assert property ($rose(resume_drive)
        |-> idle_q >= SUSP_CYCLES - 1) else $error("resume too early");
    AST_RES_LEN: assert property ($fell(resume_drive) |->
        run_q >= RESUME_CYCLES - 1 && run_q <= RESUME_CYCLES + 1)
        else $error("resume length");
    AST_PRIO_WRITE: assert property ($changed(usb_prio)
        |-> $past(wb_cyc_i && wb_we_i && wb_adr_i == A_PRIO) ||
        $past(bus_reset_end) || $past(bus_reset_end, 2))
        else $error("prio changed");
    COV_RES: cover property ($rose(resume_drive));
    COV_STALL: cover property (send_stall);
    COV_PAD: cover property ($rose(pad_idle));
endmodule
bind usb_bus_events usb_bus_events_chk #(.SUSP_CYCLES(SUSP_CYCLES),
    .RESUME_CYCLES(RESUME_CYCLES)) chk (.sys_clk, .rst, .clk_en, .wb_adr_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bus_reset_end, .token_pulse,
    .bus_idle, .send_stall, .pad_idle, .resume_drive, .vref_out, .vref_oe_n,
    .usb_prio);

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
    import usb_evt_pkg::*;
    localparam int IC = 40;
    localparam int SC = 30;
    logic sys_clk = 0, rst = 1, clk_en = 1;
    logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic bus_reset_end, sof_pulse, sof_crc_ok, setup_pulse, setup_is_control;
    logic token_pulse, data_accept, data_pid1, nak_in_sent, nak_out_sent;
    logic bus_idle, send_stall, expect_data1, pad_idle, resume_drive;
    logic vref_out, vref_oe_n, usb_irq;
    logic [10:0] sof_frame;
    logic [2:0] tok_ep;
    logic [1:0] usb_prio;
    int errors = 0, checks_done = 0, seed = 32'hb9bb3257, n, f, ep;
    usb_bus_events #(.IDLE_CYCLES(IC), .SUSP_CYCLES(SC),
        .RESUME_CYCLES(10)) dut (
        .sys_clk, .rst, .clk_en, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
        .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bus_reset_end, .sof_pulse,
        .sof_frame, .sof_crc_ok, .setup_pulse, .setup_is_control, .tok_ep,
        .token_pulse, .data_accept, .data_pid1, .nak_in_sent, .nak_out_sent,
        .bus_idle, .send_stall, .expect_data1, .pad_idle, .resume_drive,
        .vref_out, .vref_oe_n, .usb_irq, .usb_prio);
    usb_host_model host (.sys_clk, .bus_reset_end, .sof_pulse, .sof_frame,
        .sof_crc_ok, .setup_pulse, .setup_is_control, .tok_ep, .token_pulse,
        .data_accept, .data_pid1, .nak_in_sent, .nak_out_sent, .bus_idle,
        .send_stall, .expect_data1);
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic summarize;
        if (errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(0, a, 0);
        checks_done++;
        if (q !== e) begin
            errors++;
            $display("CHECK FAILED reg %h exp %h got %h", a, e, q);
        end
    endtask
    task automatic pc(input string s, input logic [1:0] e,
            input logic [1:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 0;
        rc(A_GCTRL, 0);
        pc("oe_n", 0, vref_oe_n);
        rc(8'h40, 0);
        wb(1, A_ENABLE, 32'h7f);
        wb(1, A_GCTRL, 32'h80);
        for (int p = 0; p < 4; p++) begin
            wb(1, A_PRIO, p);
            @(posedge sys_clk);
            pc("prio", p[1:0], usb_prio);
        end
        for (int i = 0; i < 2; i++) begin
            f = $random(seed);
            host.ev(1, f[10:0], i[0]);
            rc(A_FNUML, f[7:0]);
            rc(A_FNUMH, f[10:8]);
            rc(A_EPSTAT, {25'h0, ~i[0], i[0], 5'h00});
            rc(A_EVENT, 2);
            pc("irq", 1, usb_irq);
            wb(1, A_EVENT, 2);
            rc(A_EVENT, 0);
        end
        @(posedge sys_clk);
        clk_en <= 0;
        host.ev(1, 0, 1);
        clk_en <= 1;
        rc(A_EVENT, 0);
        ep = $random(seed) & 7;
        wb(1, A_EPSEL, ep);
        wb(1, A_EPSTAT, 1);
        host.ev(3, ep ^ 1, 0);
        pc("stall", 0, host.stalled);
        host.ev(3, ep, 0);
        pc("stall", 1, host.stalled);
        rc(A_EPSTAT, 32'h23);
        pc("irq", 1, usb_irq);
        host.ev(2, ep, 0);
        rc(A_EPSTAT, 32'h21);
        host.ev(2, ep, 1);
        rc(A_EPSTAT, 32'h20);
        host.ev(4, ep, 0);
        pc("data1", 1, host.d1);
        rc(A_EPSTAT, 32'h30);
        host.ev(4, ep, 1);
        pc("data1", 0, host.d1);
        rc(A_EPSTAT, 32'h20);
        host.ev(4, ep, 0);
        wb(1, A_EPRST, 1 << ep);
        rc(A_EPSTAT, 32'h20);
        host.ev(5, ep, 0);
        host.ev(6, ep, 0);
        rc(A_EPSTAT, 32'h2c);
        wb(1, A_EPSTAT, 32'h0c);
        rc(A_EPSTAT, 32'h20);
        host.idle(1);
        repeat (IC + 4) @(posedge sys_clk);
        rc(A_EVENT, 4);
        wb(1, A_EVENT, 4);
        wb(1, A_GCTRL, 32'hc0);
        @(posedge sys_clk);
        pc("pad", 1, pad_idle);
        host.idle(0);
        repeat (3) @(posedge sys_clk);
        pc("pad", 0, pad_idle);
        host.ev(1, 0, 1);
        rc(A_EVENT, 8);
        wb(1, A_EVENT, 8);
        wb(1, A_GCTRL, 32'h84);
        host.idle(1);
        wb(1, A_GCTRL, 32'ha4);
        n = 0;
        while (resume_drive !== 1'b1) begin
            @(posedge sys_clk);
            n++;
        end
        pc("early", 1, n >= SC - 2);
        rc(A_GCTRL, 32'hac);
        while (resume_drive === 1'b1) @(posedge sys_clk);
        rc(A_GCTRL, 32'ha4);
        wb(1, A_GCTRL, 32'h90);
        host.idle(0);
        pc("oe_n", 1, vref_oe_n);
        wb(1, A_PRIO, 3);
        host.ev(0, 0, 0);
        rc(A_GCTRL, 32'h80);
        rc(A_ENABLE, 0);
        pc("prio", 0, usb_prio);
        pc("oe_n", 0, vref_oe_n);
        rc(A_EVENT, 1);
        wb(1, A_ENABLE, 1);
        @(posedge sys_clk);
        pc("irq", 1, usb_irq);
        wb(1, A_EVENT, 1);
        rc(A_EVENT, 0);
        summarize();
    end
endmodule
